// >>> pbc_pkg.sv
package pbc_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int          PBC_NPINS_DEF  = 16;
  localparam int          PBC_NPINS_MAX  = 32;
  localparam logic [31:0] PBC_SHARED_DEF = 32'h0000000F;

  // ---------------------------------------------------------------
  // mode encodings {high, mid, low}
  // ---------------------------------------------------------------
  localparam logic [2:0] PBC_CFG_ANALOG  = 3'h0;
  localparam logic [2:0] PBC_CFG_TTL_IN  = 3'h1;
  localparam logic [2:0] PBC_CFG_CMOS_IN = 3'h2;
  localparam logic [2:0] PBC_CFG_PULL_IN = 3'h3;
  localparam logic [2:0] PBC_CFG_OUT_OD  = 3'h4;
  localparam logic [2:0] PBC_CFG_OUT_PP  = 3'h5;
  localparam logic [2:0] PBC_CFG_AF_OD   = 3'h6;
  localparam logic [2:0] PBC_CFG_AF_PP   = 3'h7;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] PBC_CFG_RST    = PBC_CFG_PULL_IN;
  localparam logic       PBC_DATA_RST   = 1'h1;
  localparam logic       PBC_PIN_RST    = 1'h1;
  localparam logic       PBC_AF_IDLE    = 1'h1;
  localparam logic       PBC_ANALOG_RD  = 1'h0;
  localparam logic       PBC_DRIVE_RST     = 1'h0;
  localparam logic       PBC_PULL_UP_RST   = 1'h1;
  localparam logic       PBC_PULL_DOWN_RST = 1'h0;
  localparam logic       PBC_BUF_SEL_RST   = 1'h0;

endpackage

// >>> pbc_sync.sv
`timescale 1ns/1ps
module pbc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out
);
  import pbc_pkg::*;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic lvl_reg;
      // s1 feeds only s2; a new level counts once s2 and s3 agree
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_reg  <= PBC_PIN_RST;
          s2_reg  <= PBC_PIN_RST;
          s3_reg  <= PBC_PIN_RST;
          lvl_reg <= PBC_PIN_RST;
        end else begin
          s1_reg <= async_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            lvl_reg <= s3_reg;
          end
        end
      end
      assign level_out[i] = lvl_reg;
    end
  endgenerate

endmodule // pbc_sync

// >>> pbc_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// - three bits pick mode; analog reads zero
// - mode 011: pull from data bit
// - 101 push-pull reads latch; 100 open-drain
// - 110 alternate open-drain, reads pin
// - 111 alternate push-pull, reads pin
// - shared pins default to uart/i2c function
// - spi takes shared pins only when enabled
module pbc_port #(
  parameter int          NPINS       = pbc_pkg::PBC_NPINS_DEF,
  parameter logic [31:0] SHARED_MASK = pbc_pkg::PBC_SHARED_DEF
) (
  input  wire logic             CORE_CLK,
  input  wire logic             RST_N,
  input  wire logic             DATA_WR,
  input  wire logic [NPINS-1:0] DATA_WDATA,
  input  wire logic             CFG_WR,
  input  wire logic [NPINS-1:0] CFG_HIGH_WDATA,
  input  wire logic [NPINS-1:0] CFG_MID_WDATA,
  input  wire logic [NPINS-1:0] CFG_LOW_WDATA,
  input  wire logic             SPI_EN,
  input  wire logic [NPINS-1:0] PIN_IN,
  input  wire logic [NPINS-1:0] PRI_AF_OUT,
  input  wire logic [NPINS-1:0] SPI_AF_OUT,
  output logic      [NPINS-1:0] PIN_OUT,
  output logic      [NPINS-1:0] PIN_OE,
  output logic      [NPINS-1:0] PULL_UP_EN,
  output logic      [NPINS-1:0] PULL_DOWN_EN,
  output logic      [NPINS-1:0] ANALOG_EN,
  output logic      [NPINS-1:0] TTL_SEL,
  output logic      [NPINS-1:0] PRI_AF_IN,
  output logic      [NPINS-1:0] SPI_AF_IN,
  output logic      [NPINS-1:0] DATA_RDATA,
  output logic      [NPINS-1:0] CFG_HIGH_RDATA,
  output logic      [NPINS-1:0] CFG_MID_RDATA,
  output logic      [NPINS-1:0] CFG_LOW_RDATA
);
  import pbc_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  generate
    if (NPINS < 1 || NPINS > PBC_NPINS_MAX) begin : g_bad_npins
      $error("pbc_port: NPINS must be 1 to 32");
    end
  endgenerate

  // ---------------------------------------------------------------
  // pin level synchroniser
  // ---------------------------------------------------------------
  logic [NPINS-1:0] pin_lvl;

  pbc_sync #(
    .WIDTH (NPINS)
  ) u_sync (
    .clk       (CORE_CLK),
    .rst_n     (RST_N),
    .async_in  (PIN_IN),
    .level_out (pin_lvl)
  );

  // ---------------------------------------------------------------
  // per-pin configuration
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NPINS; i++) begin : g_pin
      logic       port_data_reg;
      logic       port_cfg_high_reg;
      logic       port_cfg_mid_reg;
      logic       port_cfg_low_reg;
      logic [2:0] cfg;
      logic       data_locked;
      logic       spi_route;
      logic       af_out;
      logic       out_next;
      logic       oe_next;
      logic       pu_next;
      logic       pd_next;
      logic       rd_next;
      logic       out_reg;
      logic       oe_reg;
      logic       pu_reg;
      logic       pd_reg;
      logic       an_reg;
      logic       ttl_reg;
      logic       rd_reg;
      logic       pri_in_reg;
      logic       spi_in_reg;

      assign cfg = {port_cfg_high_reg, port_cfg_mid_reg, port_cfg_low_reg};

      // data writes are dropped in analog and in both alternate-function modes
      assign data_locked = (cfg == PBC_CFG_ANALOG) ||
                           (cfg == PBC_CFG_AF_OD)  ||
                           (cfg == PBC_CFG_AF_PP);

      always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
          port_cfg_high_reg <= PBC_CFG_RST[2];
          port_cfg_mid_reg  <= PBC_CFG_RST[1];
          port_cfg_low_reg  <= PBC_CFG_RST[0];
        end else if (CFG_WR) begin
          port_cfg_high_reg <= CFG_HIGH_WDATA[i];
          port_cfg_mid_reg  <= CFG_MID_WDATA[i];
          port_cfg_low_reg  <= CFG_LOW_WDATA[i];
        end
      end

      // lock is judged on the mode in force before a same-cycle cfg write
      always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
          port_data_reg <= PBC_DATA_RST;
        end else if (DATA_WR && !data_locked) begin
          port_data_reg <= DATA_WDATA[i];
        end
      end

      // only shared pins can be stolen by spi, and only with the enable set
      assign spi_route = SHARED_MASK[i] && SPI_EN;
      assign af_out    = spi_route ? SPI_AF_OUT[i] : PRI_AF_OUT[i];

      // ---------------------------------------------------------------
      // mode decode
      // ---------------------------------------------------------------
      always_comb begin
        out_next = 1'h0;
        oe_next  = 1'h0;
        pu_next  = 1'h0;
        pd_next  = 1'h0;
        rd_next  = pin_lvl[i];
        unique case (cfg)
          PBC_CFG_ANALOG: begin
            rd_next = PBC_ANALOG_RD;
          end
          PBC_CFG_TTL_IN, PBC_CFG_CMOS_IN: begin
            rd_next = pin_lvl[i];
          end
          PBC_CFG_PULL_IN: begin
            pu_next = port_data_reg;
            pd_next = !port_data_reg;
          end
          PBC_CFG_OUT_OD: begin
            // open-drain only ever pulls low; a 1 releases the pin
            oe_next = !port_data_reg;
          end
          PBC_CFG_OUT_PP: begin
            out_next = port_data_reg;
            oe_next  = 1'h1;
            rd_next  = port_data_reg;
          end
          PBC_CFG_AF_OD: begin
            oe_next = !af_out;
          end
          PBC_CFG_AF_PP: begin
            out_next = af_out;
            oe_next  = 1'h1;
          end
        endcase
      end

      // ---------------------------------------------------------------
      // registered pad controls and read view
      // ---------------------------------------------------------------
      // pad controls are flops so a decode glitch never reaches a pin
      always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
          out_reg <= PBC_DRIVE_RST;
          oe_reg  <= PBC_DRIVE_RST;
        end else begin
          out_reg <= out_next;
          oe_reg  <= oe_next;
        end
      end

      always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
          pu_reg <= PBC_PULL_UP_RST;
          pd_reg <= PBC_PULL_DOWN_RST;
        end else begin
          pu_reg <= pu_next;
          pd_reg <= pd_next;
        end
      end

      always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
          an_reg  <= PBC_BUF_SEL_RST;
          ttl_reg <= PBC_BUF_SEL_RST;
        end else begin
          an_reg  <= (cfg == PBC_CFG_ANALOG);
          ttl_reg <= (cfg == PBC_CFG_TTL_IN);
        end
      end

      // read view lags the mode by one edge, like the pad controls
      always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
          rd_reg <= PBC_PIN_RST;
        end else begin
          rd_reg <= rd_next;
        end
      end

      // the pin level reaches only the selected peripheral; the other sees idle
      always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
          pri_in_reg <= PBC_AF_IDLE;
          spi_in_reg <= PBC_AF_IDLE;
        end else begin
          pri_in_reg <= (cfg[2] && cfg[1] && !spi_route) ? pin_lvl[i] : PBC_AF_IDLE;
          spi_in_reg <= (cfg[2] && cfg[1] && spi_route) ? pin_lvl[i] : PBC_AF_IDLE;
        end
      end

      assign PIN_OUT[i]        = out_reg;
      assign PIN_OE[i]         = oe_reg;
      assign PULL_UP_EN[i]     = pu_reg;
      assign PULL_DOWN_EN[i]   = pd_reg;
      assign ANALOG_EN[i]      = an_reg;
      assign TTL_SEL[i]        = ttl_reg;
      assign DATA_RDATA[i]     = rd_reg;
      assign PRI_AF_IN[i]      = pri_in_reg;
      assign SPI_AF_IN[i]      = spi_in_reg;
      assign CFG_HIGH_RDATA[i] = port_cfg_high_reg;
      assign CFG_MID_RDATA[i]  = port_cfg_mid_reg;
      assign CFG_LOW_RDATA[i]  = port_cfg_low_reg;
    end
  endgenerate

endmodule // pbc_port

// >>> pbc_port_props.sv
`timescale 1ns/1ps
module pbc_port_props #(
  parameter int          NPINS       = pbc_pkg::PBC_NPINS_DEF,
  parameter logic [31:0] SHARED_MASK = pbc_pkg::PBC_SHARED_DEF
) (
  input wire logic             CORE_CLK,
  input wire logic             RST_N,
  input wire logic             SPI_EN,
  input wire logic [NPINS-1:0] CFG_HIGH_RDATA,
  input wire logic [NPINS-1:0] CFG_MID_RDATA,
  input wire logic [NPINS-1:0] CFG_LOW_RDATA,
  input wire logic [NPINS-1:0] PIN_OUT,
  input wire logic [NPINS-1:0] PIN_OE,
  input wire logic [NPINS-1:0] PULL_UP_EN,
  input wire logic [NPINS-1:0] PULL_DOWN_EN,
  input wire logic [NPINS-1:0] ANALOG_EN,
  input wire logic [NPINS-1:0] TTL_SEL,
  input wire logic [NPINS-1:0] SPI_AF_IN,
  input wire logic [NPINS-1:0] DATA_RDATA
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  wire logic [NPINS-1:0] h = CFG_HIGH_RDATA;
  wire logic [NPINS-1:0] m = CFG_MID_RDATA;
  wire logic [NPINS-1:0] l = CFG_LOW_RDATA;
  // derived outputs lag the config flops by exactly one edge
  property p_analog; ANALOG_EN == $past(~h & ~m & ~l); endproperty
  a_analog: assert property (p_analog) else $error("analog enable wrong");
  property p_ttl; TTL_SEL == $past(~h & ~m & l); endproperty
  a_ttl: assert property (p_ttl) else $error("ttl select wrong");
  property p_anrd; ($past(~h & ~m & ~l) & DATA_RDATA) == '0; endproperty
  a_anrd: assert property (p_anrd) else $error("analog pin reads one");
  property p_pull; (PULL_UP_EN | PULL_DOWN_EN) == $past(~h & m & l); endproperty
  a_pull: assert property (p_pull) else $error("pull enable outside pull mode");
  property p_pull_dir; (PULL_UP_EN & PULL_DOWN_EN) == '0; endproperty
  a_pull_dir: assert property (p_pull_dir) else $error("pull up and down together");
  property p_pp; ($past(h & l) & ~PIN_OE) == '0; endproperty
  a_pp: assert property (p_pp) else $error("push-pull pin not driven");
  property p_od; ($past(h & ~l) & PIN_OUT) == '0; endproperty
  a_od: assert property (p_od) else $error("open-drain pin drives high");
  property p_in; ($past(~h) & PIN_OE) == '0; endproperty
  a_in: assert property (p_in) else $error("input pin driven");
  property p_spi; !$past(SPI_EN) |-> &SPI_AF_IN; endproperty
  a_spi: assert property (p_spi) else $error("spi routed while disabled");
  property p_shared; (~SHARED_MASK[NPINS-1:0] & ~SPI_AF_IN) == '0; endproperty
  a_shared: assert property (p_shared) else $error("spi on unshared pin");
endmodule // pbc_port_props
bind pbc_port pbc_port_props #(.NPINS(NPINS), .SHARED_MASK(SHARED_MASK)) u_props (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .SPI_EN(SPI_EN), .CFG_HIGH_RDATA(CFG_HIGH_RDATA),
  .CFG_MID_RDATA(CFG_MID_RDATA), .CFG_LOW_RDATA(CFG_LOW_RDATA), .PIN_OUT(PIN_OUT),
  .PIN_OE(PIN_OE), .PULL_UP_EN(PULL_UP_EN), .PULL_DOWN_EN(PULL_DOWN_EN),
  .ANALOG_EN(ANALOG_EN), .TTL_SEL(TTL_SEL), .SPI_AF_IN(SPI_AF_IN), .DATA_RDATA(DATA_RDATA));

// >>> pbc_pin_model.sv
`timescale 1ns/1ps
module pbc_pin_model #(
  parameter int N = 16
) (
  input  wire logic         clk,
  input  wire logic [N-1:0] oe,
  input  wire logic [N-1:0] out,
  input  wire logic [N-1:0] pu,
  input  wire logic [N-1:0] pd,
  input  wire logic         ext_en,
  input  wire logic [N-1:0] ext_val,
  output logic      [N-1:0] pin
);
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (oe[i]) pin[i] <= out[i];
      else if (ext_en) pin[i] <= ext_val[i];
      else if (pu[i]) pin[i] <= 1'h1;
      else if (pd[i]) pin[i] <= 1'h0;
      else pin[i] <= ~pin[i]; // floating: toggle so a stale level never reads as valid
    end
  end
endmodule // pbc_pin_model

// >>> test_pbc_port.sv
`timescale 1ns/1ps
module test_pbc_port;
  import pbc_pkg::*;
  localparam logic [15:0] P = 16'hA5C3, D = 16'h3C96, A = 16'h5A0F, S = 16'hC3A9;
  logic clk = 1'h0, rst_n = 1'h0, dwr = 1'h0, cwr = 1'h0, spi = 1'h0, ext_en = 1'h0;
  logic [15:0] wd = 16'h0000, ch = 16'h0000, cm = 16'h0000, cl = 16'h0000;
  logic [15:0] pin, pout, poe, pu, pd, pri_in, spi_in, rd, an, ttl;
  logic [15:0] c_h, c_m, c_l;
  int error_cnt = 0, checks = 0;
  logic [15:0] e, eo;
  pbc_port dut (.CORE_CLK(clk), .RST_N(rst_n), .DATA_WR(dwr), .DATA_WDATA(wd), .CFG_WR(cwr),
    .CFG_HIGH_WDATA(ch), .CFG_MID_WDATA(cm), .CFG_LOW_WDATA(cl), .SPI_EN(spi), .PIN_IN(pin),
    .PRI_AF_OUT(A), .SPI_AF_OUT(S), .PIN_OUT(pout), .PIN_OE(poe), .PULL_UP_EN(pu),
    .PULL_DOWN_EN(pd), .ANALOG_EN(an), .TTL_SEL(ttl), .PRI_AF_IN(pri_in), .SPI_AF_IN(spi_in),
    .DATA_RDATA(rd), .CFG_HIGH_RDATA(c_h), .CFG_MID_RDATA(c_m), .CFG_LOW_RDATA(c_l));
  pbc_pin_model #(.N(16)) u_pins (.clk(clk), .oe(poe), .out(pout), .pu(pu), .pd(pd),
    .ext_en(ext_en), .ext_val(P), .pin(pin));
  initial forever #50 clk = ~clk;
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // writes settle for 10 cycles: covers the 2-edge config and 5-edge pin paths
  task cfg(input logic [2:0] md);
    @(negedge clk) {cwr, ch, cm, cl} = {1'h1, {16{md[2]}}, {16{md[1]}}, {16{md[0]}}};
    @(negedge clk) cwr = 1'h0;
    repeat (10) @(negedge clk);
  endtask
  task wr(input logic [15:0] d);
    @(negedge clk) {dwr, wd} = {1'h1, d};
    @(negedge clk) dwr = 1'h0;
    repeat (10) @(negedge clk);
  endtask
  initial begin
    #1ms error_cnt++;
    wrap_up;
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'h1;
    repeat (10) @(negedge clk);
    chk(c_h, 16'h0000);
    chk(c_m, 16'hFFFF);
    chk(c_l, 16'hFFFF);
    chk(pu, 16'hFFFF);
    chk(rd, 16'hFFFF);
    ext_en = 1'h1;
    wr(D);
    chk(pu, D);
    chk(pd, ~D);
    for (int md = 0; md < 8; md++) begin
      cfg(md[2:0]);
      case (md)
        0: e = 16'h0000;
        4: e = P & D;
        5: e = D;
        6: e = P & A;
        7: e = A;
        default: e = P;
      endcase
      case (md)
        4: eo = ~D;
        6: eo = ~A;
        5, 7: eo = 16'hFFFF;
        default: eo = 16'h0000;
      endcase
      chk(rd, e);
      chk(poe, eo);
      chk(an, {16{md == 0}});
      chk(ttl, {16{md == 1}});
    end
    chk(pout, A);
    chk(pri_in, A);
    chk(spi_in, 16'hFFFF);
    @(negedge clk) spi = 1'h1;
    repeat (10) @(negedge clk);
    chk(pout, {A[15:4], S[3:0]});
    chk(spi_in, {12'hFFF, S[3:0]});
    chk(pri_in, {A[15:4], 4'hF});
    @(negedge clk) spi = 1'h0;
    foreach (c_h[k]) if (k < 3) begin
      cfg(3'h3);
      wr(D);
      cfg(k == 0 ? 3'h0 : (k == 1 ? 3'h6 : 3'h7));
      wr(~D);
      cfg(3'h5);
      chk(rd, D);
    end
    // a reset in mid-run must bring back the pulled-up input state and data
    @(negedge clk) rst_n = 1'h0;
    repeat (5) @(negedge clk);
    rst_n = 1'h1;
    repeat (10) @(negedge clk);
    chk(c_h, 16'h0000);
    chk(c_m, 16'hFFFF);
    chk(c_l, 16'hFFFF);
    chk(pu, 16'hFFFF);
    chk(pd, 16'h0000);
    chk(poe, 16'h0000);
    chk(rd, P);
    cfg(3'h5);
    chk(rd, 16'hFFFF);
    wrap_up;
  end
endmodule // test_pbc_port
